/* File: common/sss_pkg.sv */
// Shared types and constants for the SPI slave-select control block.
`default_nettype none
package sss_pkg;

  // Serial byte width and receive queue depth.
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [2:0]  FIRST_BIT   = 3'h0;

  // Reset values.
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic        MASTER_RST  = 1'b0;
  localparam logic        FLAG_RST    = 1'b0;

  // Shortest sampled SCK phase, in ns and in system clock cycles (least time, rounded up).
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned SCK_MIN_PH_NS  = 16;
  localparam int unsigned SCK_MIN_PH_CYC =
    (SCK_MIN_PH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // One bit for each serial pin.
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss;
  } sss_pin_set_type;

  // Operating state of the serial interface.
  typedef enum logic [1:0] {
    SSS_OFF     = 2'b00,
    SSS_MASTER  = 2'b01,
    SSS_PASSIVE = 2'b10,
    SSS_ACTIVE  = 2'b11
  } sss_state_type;

endpackage
`default_nettype wire

/* File: hdl/sss_spi_ss_ctrl.sv */
// SPI slave-select control with slave byte receiver and receive FIFO.
// Operation
// - In slave mode the slave-select pin is always an input.
// - Slave with select low: active; MISO driven only if user set it.
// - Slave with select high: passive, no reception; MISO may stay user output.
// - Select rising in slave mode resets shift logic, drops partial byte.
// - Master with select input driven low clears the master select bit.
// - Fall back sets completion flag; interrupt when both enables set.
// - After fall back stay slave until software sets master select again.
`timescale 1ns/100ps
`default_nettype none

module sss_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire  logic             clk,
  input  wire  logic             rst_n,
  // Fill side.
  input  wire  logic             in_valid,
  output logic                   in_ready,
  input  wire  logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                   out_valid,
  input  wire  logic             out_ready,
  output logic       [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module sss_spi_ss_ctrl (
  // Clock and reset.
  input  wire  logic                     clk,
  input  wire  logic                     rst_n,
  // Control inputs from the host logic.
  input  wire  logic                     spi_enable,
  input  wire  logic                     master_select_set,
  input  wire  logic                     master_select_clr,
  input  wire  logic                     intr_enable,
  input  wire  logic                     global_intr_enable,
  input  wire  logic                     flag_clear,
  input  wire  sss_pkg::sss_pin_set_type user_dir,
  input  wire  sss_pkg::sss_pin_set_type user_level,
  // Status outputs.
  output logic                           master_select_bit,
  output logic                           transfer_complete_flag,
  output logic                           spi_irq,
  output sss_pkg::sss_state_type         spi_state,
  // Transmit byte for slave mode.
  input  wire  logic                     tx_write,
  input  wire  logic [7:0]               tx_data,
  // Received byte stream.
  output logic                           rx_valid,
  input  wire  logic                     rx_ready,
  output logic [7:0]                     rx_data,
  // Serial pins, output enables active low.
  input  wire  sss_pkg::sss_pin_set_type pin_in,
  output sss_pkg::sss_pin_set_type       pin_out,
  output sss_pkg::sss_pin_set_type       pin_oe_n
);
  import sss_pkg::*;

  logic          sck_s1_r;
  logic          sck_s2_r;
  logic          sck_d_r;
  logic          mosi_s1_r;
  logic          mosi_s2_r;
  logic          ss_s1_r;
  logic          ss_s2_r;
  logic          master_r;
  logic          flag_r;
  logic [2:0]    bit_cnt_r;
  logic [7:0]    rx_sh_r;
  logic [7:0]    rx_byte_r;
  logic          pend_r;
  logic [7:0]    tx_hold_r;
  logic [7:0]    tx_sh_r;
  sss_state_type state_r;
  sss_state_type state_nxt;
  logic          sck_rise;
  logic          sck_fall;
  logic          slave_mode;
  logic          slave_act;
  logic          fallback;
  logic          byte_done;
  logic          fifo_in_ready;
  sss_pin_set_type oe_n_nxt;
  sss_pin_set_type out_nxt;

  // Two-stage synchronisers for the SCK, MOSI and select pin inputs; MISO input is not used.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_d_r   <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      ss_s1_r   <= 1'b1;
      ss_s2_r   <= 1'b1;
    end else begin
      sck_s1_r  <= pin_in.sck;
      sck_s2_r  <= sck_s1_r;
      sck_d_r   <= sck_s2_r;
      mosi_s1_r <= pin_in.mosi;
      mosi_s2_r <= mosi_s1_r;
      ss_s1_r   <= pin_in.ss;
      ss_s2_r   <= ss_s1_r;
    end
  end

  assign sck_rise   = sck_s2_r && !sck_d_r;
  assign sck_fall   = !sck_s2_r && sck_d_r;
  assign slave_mode = spi_enable && !master_r;
  // Active only while select is low.
  assign slave_act  = slave_mode && !ss_s2_r;
  // Select input low in master mode.
  assign fallback   = spi_enable && master_r && !user_dir.ss && !ss_s2_r;
  assign byte_done  = slave_act && !pend_r && sck_rise && (bit_cnt_r == LAST_BIT);

  // Master select bit: software sets or clears it, a foreign master clears it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_r <= MASTER_RST;
    // Forced clear wins; only a new write restores master.
    end else if (fallback) begin
      master_r <= 1'b0;
    end else if (master_select_set) begin
      master_r <= 1'b1;
    end else if (master_select_clr) begin
      master_r <= 1'b0;
    end
  end

  // Completion flag set on fall back or byte; set beats clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= FLAG_RST;
    end else if (fallback || byte_done) begin
      flag_r <= 1'b1;
    end else if (flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  // Receive shifter; MOSI is sampled on the rising SCK edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= FIRST_BIT;
      rx_sh_r   <= BYTE_RST;
    // Select high drops any partial byte at once.
    end else if (!slave_act) begin
      bit_cnt_r <= FIRST_BIT;
      rx_sh_r   <= BYTE_RST;
    // Passive state above never shifts; a held byte stalls here.
    end else if (sck_rise && !pend_r) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      rx_sh_r   <= {rx_sh_r[6:0], mosi_s2_r};
    end
  end

  // A finished byte waits here until the FIFO takes it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_r <= BYTE_RST;
      pend_r    <= 1'b0;
    end else if (byte_done) begin
      rx_byte_r <= {rx_sh_r[6:0], mosi_s2_r};
      pend_r    <= 1'b1;
    end else if (fifo_in_ready) begin
      pend_r    <= 1'b0;
    end
  end

  // Transmit shifter; the next bit is set up on the falling SCK edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_r <= BYTE_RST;
      tx_sh_r   <= BYTE_RST;
    end else begin
      if (tx_write) begin
        tx_hold_r <= tx_data;
      end
      // Reload the whole byte while idle or between bytes.
      if (!slave_act || byte_done) begin
        tx_sh_r <= tx_write ? tx_data : tx_hold_r;
      end else if (sck_fall && (bit_cnt_r != FIRST_BIT) && !pend_r) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  sss_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (pend_r),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte_r),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Operating state follows enable, master bit and select.
  always_comb begin
    state_nxt = SSS_OFF;
    if (spi_enable && master_r && !fallback) begin
      state_nxt = SSS_MASTER;
    end else if (spi_enable && (!master_r || fallback)) begin
      state_nxt = ss_s2_r ? SSS_PASSIVE : SSS_ACTIVE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SSS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pin direction overrides and output levels.
  always_comb begin
    oe_n_nxt = ~user_dir;
    out_nxt  = user_level;
    case (state_nxt)
      SSS_MASTER: begin
        // Select output is a plain port level.
        oe_n_nxt.ss   = ~user_dir.ss;
        out_nxt.ss    = user_level.ss;
        oe_n_nxt.miso = 1'b1;
      end
      SSS_PASSIVE, SSS_ACTIVE: begin
        oe_n_nxt.ss   = 1'b1;
        // MOSI and SCK become inputs in slave mode.
        oe_n_nxt.mosi = 1'b1;
        oe_n_nxt.sck  = 1'b1;
        // MISO only as the user configured it.
        oe_n_nxt.miso = ~user_dir.miso;
        out_nxt.miso  = tx_sh_r[7];
      end
      default: begin
        oe_n_nxt = ~user_dir;
        out_nxt  = user_level;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_n <= 4'hF;
      pin_out  <= 4'h0;
    end else begin
      pin_oe_n <= oe_n_nxt;
      pin_out  <= out_nxt;
    end
  end

  assign master_select_bit      = master_r;
  assign transfer_complete_flag = flag_r;
  assign spi_state              = state_r;
  assign spi_irq                = flag_r && intr_enable && global_intr_enable;

endmodule
`default_nettype wire

/* File: bench/sss_sva.sv */
// Port checker for the slave-select control block.
`timescale 1ns/100ps
`default_nettype none
module sss_chk (
  // Clock and reset.
  input wire logic                     clk,
  input wire logic                     rst_n,
  // Controls.
  input wire logic                     spi_enable,
  input wire logic                     master_select_set,
  input wire logic                     master_select_clr,
  input wire logic                     intr_enable,
  input wire logic                     global_intr_enable,
  input wire sss_pkg::sss_pin_set_type user_dir,
  input wire sss_pkg::sss_pin_set_type pin_in,
  // Status and pins.
  input wire logic                     master_select_bit,
  input wire logic                     transfer_complete_flag,
  input wire logic                     spi_irq,
  input wire sss_pkg::sss_state_type   spi_state,
  input wire sss_pkg::sss_pin_set_type pin_oe_n
);
  import sss_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ss_in; spi_enable && !master_select_bit |=> pin_oe_n.ss; endproperty
  a_ss_in: assert property (p_ss_in) else $error("select pin driven in slave mode");
  property p_pins; spi_enable && !master_select_bit |=> pin_oe_n.mosi && pin_oe_n.sck; endproperty
  a_pins: assert property (p_pins) else $error("slave drives mosi or sck");
  property p_pas;
    $past(spi_state) == SSS_PASSIVE && $past(spi_state, 2) == SSS_PASSIVE
      |-> !$rose(transfer_complete_flag);
  endproperty
  a_pas: assert property (p_pas) else $error("byte taken while passive");
  property p_keep; master_select_bit && user_dir.ss && !master_select_clr |=> master_select_bit;
  endproperty
  a_keep: assert property (p_keep) else $error("select output disturbed master");
  property p_fb;
    master_select_bit && !user_dir.ss && spi_enable && $fell(pin_in.ss) |-> ##[1:4] !master_select_bit;
  endproperty
  a_fb: assert property (p_fb) else $error("no fall back on select low");
  // A software clear frees the pins one cycle later; only the forced fall back is immediate.
  property p_fb_pins;
    $fell(master_select_bit) && !$past(master_select_clr) |-> pin_oe_n.mosi && pin_oe_n.sck;
  endproperty
  a_fb_pins: assert property (p_fb_pins) else $error("mosi or sck driven after fall back");
  property p_fl; $fell(master_select_bit) && !$past(master_select_clr) |-> transfer_complete_flag;
  endproperty
  a_fl: assert property (p_fl) else $error("flag not set on fall back");
  property p_irq; spi_irq == (transfer_complete_flag && intr_enable && global_intr_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow flag and enables");
  property p_hold; !master_select_bit && !master_select_set |=> !master_select_bit; endproperty
  a_hold: assert property (p_hold) else $error("master restored by itself");
  c_fb: cover property ($fell(master_select_bit) && transfer_complete_flag);
  c_rx: cover property (spi_state == SSS_ACTIVE ##1 spi_state == SSS_PASSIVE);
  c_irq: cover property ($rose(spi_irq));
endmodule
`default_nettype wire

/* File: bench/sss_spi_master_model.sv */
// External SPI master model: mode 0 frames, MSB first.
`timescale 1ns/100ps
`default_nettype none
module sss_spi_master_model (
  // Serial lines.
  output logic      sck,
  output logic      mosi,
  output logic      ss_n,
  input  wire logic miso
);
  logic [7:0] rx_byte;
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    ss_n = 1'b1;
    rx_byte = 8'h00;
  end
  task automatic select(input logic v);
    ss_n = v;
  endtask
  // Clock pulses while the select stays high, for a slave that must ignore them.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
  endtask
  // Abort raises the select after four bits, leaving a partial byte.
  task automatic xfer(input logic [7:0] b, input logic abort);
    #3 ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #80 sck = 1'b1;
      rx_byte[i] = miso;
      #80 sck = 1'b0;
      if (abort && i == 4) break;
    end
    #80 ss_n = 1'b1;
    mosi = ~mosi;
    #80;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Testbench for the slave-select control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sss_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic spi_enable, master_select_set, master_select_clr, intr_enable, global_intr_enable;
  logic flag_clear, tx_write, rx_ready, rx_valid, master_select_bit;
  logic transfer_complete_flag, spi_irq, m_sck, m_mosi, m_ss_n, miso_w;
  logic [7:0] tx_data, rx_data;
  sss_pin_set_type user_dir, user_level, pin_in, pin_out, pin_oe_n;
  sss_state_type spi_state;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  assign miso_w = pin_oe_n.miso ? 1'b1 : pin_out.miso;
  assign pin_in = '{mosi: pin_oe_n.mosi ? m_mosi : pin_out.mosi, miso: miso_w,
                    sck: pin_oe_n.sck ? m_sck : pin_out.sck, ss: pin_oe_n.ss ? m_ss_n : pin_out.ss};
  sss_spi_ss_ctrl dut (.clk, .rst_n, .spi_enable, .master_select_set, .master_select_clr,
    .intr_enable, .global_intr_enable, .flag_clear, .user_dir, .user_level, .master_select_bit,
    .transfer_complete_flag, .spi_irq, .spi_state, .tx_write, .tx_data, .rx_valid, .rx_ready,
    .rx_data, .pin_in, .pin_out, .pin_oe_n);
  sss_spi_master_model m (.sck(m_sck), .mosi(m_mosi), .ss_n(m_ss_n), .miso(miso_w));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic t_fill();
    tx_data = 8'h3C;
    pulse(tx_write);
    m.xfer(8'hFF, 1'b1);
    chk(rx_valid === 1'b0, "partial byte kept");
    for (int i = 0; i < 17; i++) begin
      m.xfer(8'(i * 13), 1'b0);
      chk(m.rx_byte === 8'h3C, "miso byte");
    end
    chk(spi_irq === 1'b1 && pin_oe_n.mosi === 1'b1, "slave irq or pins");
  endtask
  task automatic t_drain();
    tick(1);
    rx_ready = 1'b1;
    for (int i = 0; i < 17; i++) begin
      for (int w = 0; w < 8 && rx_valid !== 1'b1; w++) tick(1);
      chk(rx_valid === 1'b1 && rx_data === 8'(i * 13), "fifo order");
      tick(1);
    end
    rx_ready = 1'b0;
    tick(3);
    chk(rx_valid === 1'b0, "fifo not empty");
  endtask
  task automatic t_passive();
    chk(spi_state === SSS_PASSIVE && pin_oe_n.miso === 1'b0 && pin_oe_n.ss === 1'b1, "passive");
    pulse(flag_clear);
    tick(1);
    chk(transfer_complete_flag === 1'b0 && spi_irq === 1'b0, "flag clear");
    m.idle_clocks(8);
    tick(1);
    chk(transfer_complete_flag === 1'b0 && rx_valid === 1'b0, "passive took data");
  endtask
  task automatic t_master_out();
    user_level = 4'hA;
    pulse(master_select_set);
    tick(6);
    chk(master_select_bit === 1'b1 && spi_state === SSS_MASTER, "master lost");
    chk(pin_oe_n.ss === 1'b0 && pin_out.ss === 1'b0 && transfer_complete_flag === 1'b0, "ss out");
    chk(pin_out.mosi === 1'b1 && pin_out.sck === 1'b1, "user levels");
    pulse(master_select_clr);
    user_level = 4'h0;
    tick(4);
  endtask
  task automatic t_fallback();
    user_dir.ss = 1'b0;
    pulse(master_select_set);
    tick(4);
    chk(master_select_bit === 1'b1 && pin_oe_n.mosi === 1'b0, "master up");
    m.select(1'b0);
    tick(5);
    chk(master_select_bit === 1'b0 && transfer_complete_flag === 1'b1, "fall back");
    chk(spi_irq === 1'b1 && pin_oe_n.mosi === 1'b1 && pin_oe_n.sck === 1'b1, "fb pins");
    chk(spi_irq === 1'b1 && master_select_bit === 1'b0, "irq without master lost");
    intr_enable = 1'b0;
    tick(1);
    chk(spi_irq === 1'b0, "irq not masked");
    intr_enable = 1'b1;
    m.select(1'b1);
    tick(30);
    chk(master_select_bit === 1'b0, "master restored by itself");
    pulse(master_select_set);
    tick(4);
    chk(master_select_bit === 1'b1, "master not restored");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {spi_enable, intr_enable, global_intr_enable} = 3'h7;
    {master_select_set, master_select_clr, flag_clear, tx_write, rx_ready} = 5'h00;
    user_dir = 4'hF;
    user_level = 4'h0;
    tx_data = 8'h00;
    tick(8);
    chk(pin_oe_n === 4'hF && master_select_bit === 1'b0 && spi_state === SSS_OFF, "reset");
    rst_n = 1'b1;
    tick(2);
    t_fill();
    t_drain();
    t_passive();
    t_master_out();
    t_fallback();
    close_out();
  end
endmodule
bind sss_spi_ss_ctrl sss_chk u_chk (.clk, .rst_n, .spi_enable, .master_select_set,
  .master_select_clr, .intr_enable, .global_intr_enable, .user_dir, .pin_in, .master_select_bit,
  .transfer_complete_flag, .spi_irq, .spi_state, .pin_oe_n);
`default_nettype wire
